//--- kmdl_pkg.sv
// Shared constants and helpers for the keyboard/mouse device link
package kmdl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int HALF_BIT_NS   = 40_000;
  localparam int START_GAP_US  = 100;
  localparam int INHIBIT_US    = 100;
  localparam int TMR_W         = 11;
  // Half of one link clock period, inside the 30..50 us window
  localparam logic [TMR_W-1:0] HALF_CYC =
    TMR_W'(HALF_BIT_NS / CLK_PERIOD_NS);
  // Least times round up
  localparam logic [TMR_W-1:0] GAP_CYC =
    TMR_W'((START_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] INH_CYC =
    TMR_W'((INHIBIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Ignore own clock release until the synchroniser has caught up
  localparam logic [TMR_W-1:0] SETTLE_CYC = 11'h008;

  // ****************************************************************
  // Framing
  // ****************************************************************
  localparam logic [3:0] FRAME_BITS  = 4'hB;
  localparam logic [3:0] LAST_BIT    = 4'hA;
  localparam int         TX_FIFO_LEN = 16;

  function automatic logic odd_parity(input logic [7:0] d);
    return ~^d;
  endfunction : odd_parity

  function automatic logic frame_bit(input logic [7:0] d,
                                     input logic [3:0] i);
    logic [10:0] f;
    f = {1'b1, odd_parity(d), d, 1'b0};
    return f[i];
  endfunction : frame_bit

endpackage : kmdl_pkg

//--- kmdl_link_if.sv
// Two-wire open-drain link between device end and host end
`timescale 1ns/1ps
interface kmdl_link_if;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic host_clk_o;
  logic host_clk_oe;
  logic host_data_o;
  logic host_data_oe;
  logic clk_line;
  logic data_line;

  // Pull-up wins unless an enabled driver pulls low
  assign clk_line  = !((dev_clk_oe && !dev_clk_o) ||
                       (host_clk_oe && !host_clk_o));
  assign data_line = !((dev_data_oe && !dev_data_o) ||
                       (host_data_oe && !host_data_o));

  modport device (input clk_line, input data_line,
                  output dev_clk_o, output dev_clk_oe,
                  output dev_data_o, output dev_data_oe);
  modport host (input clk_line, input data_line,
                output host_clk_o, output host_clk_oe,
                output host_data_o, output host_data_oe);
endinterface : kmdl_link_if

//--- kmdl_device.sv
// Device end of the link: clock generator, framer, FIFO, receiver
// What this block does
// - Start sending only with both lines high
// - Device alone makes clock pulses
// - Data low, clock high: start receiving
// - Frame: start, 8 bits LSB first, parity, stop
// - Parity makes the ones count odd
// - Bad parity marks byte invalid
// - Host inhibits by clock low 100 us
// - Inhibit before 11th pulse: abort, resend byte
// - Receive flag set stalls transmit logic
// - Pointer clear empties transmit FIFO
// - Device changes data while clock high
// - Host: inhibit, data low, release clock
// - Poll request-to-send within 10 ms
// - Clock in data, parity, stop from host
// - Device samples host data while clock high
// - After stop: data low, one final pulse
// - Data still low: keep pulsing until released
// - 16-byte FIFO, 1 to 16 byte bursts
// - Received byte held in second buffer
// - Bad start, parity, stop flag frame error
// - Override makes pins follow force values
// - First start bit 100 us after start
// - 100 us gap between burst bytes
`timescale 1ns/1ps

// ******************************************************************
// Transmit FIFO
// ******************************************************************
module kmdl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign cnt_nxt   = clear ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock)
    if (push)
      mem[wr_r] <= in_data;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      wr_r     <= '0;
      rd_r     <= '0;
      cnt_r    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      // Clearing drops everything pending, including a same-cycle push
      wr_r     <= clear ? '0 : (push ? AW'(wr_r + 1'b1) : wr_r);
      rd_r     <= clear ? '0 : (pop ? AW'(rd_r + 1'b1) : rd_r);
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL_CNT);
    end
endmodule : kmdl_fifo

// ******************************************************************
// Device end
// ******************************************************************
module kmdl_device
  import kmdl_pkg::*;
#(
  parameter int FIFO_DEPTH = TX_FIFO_LEN
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  kmdl_link_if.device     link,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       transmit_word_first,
  input  wire logic [3:0] transmit_length_select,
  input  wire logic       fifo_pointer_clear,
  input  wire logic       soft_override,
  input  wire logic       force_clock_value,
  input  wire logic       force_data_value,
  input  wire logic       receive_event_clear,
  output logic            receive_event_flag,
  output logic [7:0]      rx_data,
  output logic            frame_error
);
  typedef enum logic [2:0] {D_IDLE, D_GAP, D_TX, D_RX, D_ACK} kmdl_dstate_e;

  kmdl_dstate_e     state_r;
  logic [1:0]       clk_sync_r;
  logic [1:0]       dat_sync_r;
  logic             clk_s;
  logic             dat_s;
  logic [TMR_W-1:0] tmr_r;
  logic             tick;
  logic             hi_r;
  logic [3:0]       bit_r;
  logic [10:0]      shift_r;
  logic [7:0]       cur_r;
  logic [4:0]       rem_r;
  logic             retry_r;
  logic             stop_r;
  logic             xtra_r;
  logic             done_r;
  logic             clk_drv_r;
  logic             dat_drv_r;
  logic [7:0]       fifo_data;
  logic             fifo_valid;
  logic             fifo_pop;
  logic             bus_idle;

  assign clk_s    = clk_sync_r[1];
  assign dat_s    = dat_sync_r[1];
  assign tick     = (tmr_r == 11'h001);
  assign bus_idle = clk_s && dat_s;
  assign fifo_pop = (state_r == D_GAP) && bus_idle && tick && !retry_r;

  // Open-drain: the output value is always low, only the enable moves
  assign link.dev_clk_o  = 1'b0;
  assign link.dev_data_o = 1'b0;

  kmdl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clock     (clock),
    .rst_n     (rst_n),
    .clear     (fifo_pointer_clear),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************************************
  // Line synchronisers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      clk_sync_r <= 2'h3;
      dat_sync_r <= 2'h3;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[0], link.clk_line};
      dat_sync_r <= {dat_sync_r[0], link.data_line};
    end

  // ****************************************************************
  // Link engine
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      state_r   <= D_IDLE;
      tmr_r     <= '0;
      hi_r      <= 1'b1;
      bit_r     <= '0;
      shift_r   <= '0;
      cur_r     <= '0;
      rem_r     <= '0;
      retry_r   <= 1'b0;
      stop_r    <= 1'b0;
      xtra_r    <= 1'b0;
      done_r    <= 1'b0;
      clk_drv_r <= 1'b0;
      dat_drv_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (tmr_r != '0)
        tmr_r <= tmr_r - 1'b1;
      if (transmit_word_first)
        rem_r <= {1'b0, transmit_length_select} + 5'h01;
      case (state_r)
        D_IDLE:
        begin
          clk_drv_r <= 1'b0;
          dat_drv_r <= 1'b0;
          hi_r      <= 1'b1;
          bit_r     <= '0;
          xtra_r    <= 1'b0;
          // Checked every cycle, far inside the polling limit
          if (clk_s && !dat_s)
          begin
            state_r <= D_RX;
            tmr_r   <= HALF_CYC;
          end
          // Any transmit waits while software owns the last byte
          else if (bus_idle && !receive_event_flag &&
                   (retry_r || (rem_r != '0 && fifo_valid)))
          begin
            state_r <= D_GAP;
            tmr_r   <= GAP_CYC;
          end
        end
        D_GAP:
          if (!bus_idle)
            state_r <= D_IDLE;
          else if (tick)
          begin
            state_r   <= D_TX;
            tmr_r     <= HALF_CYC;
            retry_r   <= 1'b0;
            dat_drv_r <= 1'b1; // Start bit while clock high
            if (!retry_r)
            begin
              cur_r <= fifo_data;
              rem_r <= rem_r - 5'h01;
            end
          end
        D_TX:
          if (hi_r && !clk_s && tmr_r <= HALF_CYC - SETTLE_CYC)
          begin
            // Host inhibit seen before the 11th pulse: keep byte
            state_r   <= D_IDLE;
            retry_r   <= 1'b1;
            dat_drv_r <= 1'b0;
          end
          else if (tick)
          begin
            tmr_r <= HALF_CYC;
            hi_r  <= !hi_r;
            clk_drv_r <= hi_r;
            if (!hi_r)
            begin
              if (bit_r == LAST_BIT)
              begin
                state_r   <= D_IDLE;
                dat_drv_r <= 1'b0;
              end
              else
              begin
                bit_r     <= bit_r + 4'h1;
                // Data moves only at the start of a high half
                dat_drv_r <= !frame_bit(cur_r, bit_r + 4'h1);
              end
            end
          end
        D_RX:
          if (tick)
          begin
            tmr_r     <= HALF_CYC;
            hi_r      <= !hi_r;
            clk_drv_r <= hi_r;
            if (hi_r)
            begin
              // Sample at the end of the high half
              if (!xtra_r)
                shift_r <= {dat_s, shift_r[10:1]};
              if (bit_r == LAST_BIT)
              begin
                stop_r <= dat_s;
                xtra_r <= 1'b1;
              end
            end
            else if (bit_r != LAST_BIT)
              bit_r <= bit_r + 4'h1;
            else if (stop_r)
            begin
              state_r   <= D_ACK;
              dat_drv_r <= 1'b1;
            end
            // Otherwise one more pulse: host still holds data
          end
        D_ACK:
          if (tick)
          begin
            tmr_r     <= HALF_CYC;
            hi_r      <= !hi_r;
            clk_drv_r <= hi_r;
            if (!hi_r)
            begin
              dat_drv_r <= 1'b0;
              state_r   <= D_IDLE;
              done_r    <= 1'b1;
            end
          end
        default:
          state_r <= D_IDLE;
      endcase
    end

  // ****************************************************************
  // Receive holding buffer
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      rx_data            <= '0;
      frame_error        <= 1'b0;
      receive_event_flag <= 1'b0;
    end
    else
    begin
      if (done_r)
      begin
        rx_data     <= shift_r[8:1];
        frame_error <= shift_r[0] || !shift_r[10] ||
                       (shift_r[9] != odd_parity(shift_r[8:1]));
      end
      // A new byte beats a clear in the same cycle
      receive_event_flag <= done_r ||
                            (receive_event_flag && !receive_event_clear);
    end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      link.dev_clk_oe  <= 1'b0;
      link.dev_data_oe <= 1'b0;
    end
    else
    begin
      link.dev_clk_oe  <= soft_override ? !force_clock_value
                                        : clk_drv_r;
      link.dev_data_oe <= soft_override ? !force_data_value
                                        : dat_drv_r;
    end
endmodule : kmdl_device

//--- kmdl_host.sv
// Host end of the link: inhibit, request-to-send, byte framing
`timescale 1ns/1ps
module kmdl_host
  import kmdl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  kmdl_link_if.host       link,
  input  wire logic [7:0] send_data,
  input  wire logic       send_valid,
  output logic            send_ready,
  output logic            send_acked,
  input  wire logic       inhibit,
  output logic [7:0]      recv_data,
  output logic            recv_valid,
  output logic            recv_error
);
  typedef enum logic [1:0] {H_IDLE, H_INH, H_SEND} kmdl_hstate_e;

  kmdl_hstate_e     state_r;
  logic [2:0]       clk_sync_r;
  logic [1:0]       dat_sync_r;
  logic             dat_s;
  logic             fall;
  logic [TMR_W-1:0] tmr_r;
  logic [7:0]       byte_r;
  logic [3:0]       cnt_r;
  logic [10:0]      rshift_r;
  logic [10:0]      rframe;

  assign dat_s  = dat_sync_r[1];
  assign fall   = clk_sync_r[2] && !clk_sync_r[1];
  assign rframe = {dat_s, rshift_r[10:1]};

  assign link.host_clk_o  = 1'b0;
  assign link.host_data_o = 1'b0;

  // ****************************************************************
  // Line synchronisers and edge finder
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      clk_sync_r <= 3'h7;
      dat_sync_r <= 2'h3;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[1:0], link.clk_line};
      dat_sync_r <= {dat_sync_r[0], link.data_line};
    end

  // ****************************************************************
  // Host sequencer
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      state_r           <= H_IDLE;
      tmr_r             <= '0;
      byte_r            <= '0;
      cnt_r             <= '0;
      rshift_r          <= '0;
      send_ready        <= 1'b0;
      send_acked        <= 1'b0;
      recv_data         <= '0;
      recv_valid        <= 1'b0;
      recv_error        <= 1'b0;
      link.host_clk_oe  <= 1'b0;
      link.host_data_oe <= 1'b0;
    end
    else
    begin
      send_acked <= 1'b0;
      recv_valid <= 1'b0;
      if (tmr_r != '0)
        tmr_r <= tmr_r - 1'b1;
      case (state_r)
        H_IDLE:
        begin
          link.host_clk_oe  <= inhibit;
          link.host_data_oe <= 1'b0;
          send_ready        <= !inhibit;
          if (send_valid && send_ready)
          begin
            // Hold clock low for the full inhibit time first
            state_r          <= H_INH;
            byte_r           <= send_data;
            tmr_r            <= INH_CYC;
            send_ready       <= 1'b0;
            link.host_clk_oe <= 1'b1;
            cnt_r            <= '0;
          end
          else if (inhibit)
            cnt_r <= '0;
          else if (fall)
          begin
            // Device frame: sample while clock is low
            rshift_r <= rframe;
            cnt_r    <= cnt_r + 4'h1;
            if (cnt_r == LAST_BIT)
            begin
              cnt_r      <= '0;
              recv_valid <= 1'b1;
              recv_data  <= rframe[8:1];
              recv_error <= rframe[0] || !rframe[10] ||
                            (rframe[9] != odd_parity(rframe[8:1]));
            end
          end
        end
        H_INH:
          if (tmr_r == 11'h002)
            link.host_data_oe <= 1'b1;
          else if (tmr_r == 11'h001)
          begin
            link.host_clk_oe <= 1'b0;
            state_r          <= H_SEND;
          end
        H_SEND:
          if (fall)
          begin
            cnt_r <= cnt_r + 4'h1;
            // Data moves only while clock is low
            if (cnt_r < LAST_BIT)
              link.host_data_oe <= !frame_bit(byte_r, cnt_r + 4'h1);
            else if (cnt_r == FRAME_BITS)
            begin
              // Acknowledge pulse: device holds data low
              send_acked <= !dat_s;
              cnt_r      <= '0;
              state_r    <= H_IDLE;
            end
          end
        default:
          state_r <= H_IDLE;
      endcase
    end
endmodule : kmdl_host

//--- kmdl_checker.sv
// Concurrent checks on the open-drain link between device and host
`timescale 1ns/1ps
module kmdl_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic host_clk_o,
  input wire logic host_clk_oe,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic clk_line,
  input wire logic data_line
);
  localparam int HALF_N = 400;
  localparam int RTS_N  = 410;
  logic [10:0] lo_cnt_r;
  logic [10:0] hlo_cnt_r;
  logic [10:0] quiet_cnt_r;

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) lo_cnt_r <= 11'h000;
    else lo_cnt_r <= dev_clk_oe ? lo_cnt_r + 11'h001 : 11'h000;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) hlo_cnt_r <= 11'h000;
    else if (!host_clk_oe) hlo_cnt_r <= 11'h000;
    else if (hlo_cnt_r != 11'h7FF) hlo_cnt_r <= hlo_cnt_r + 11'h001;

  // Saturates so long idle spells never wrap into a short gap
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) quiet_cnt_r <= 11'h000;
    else if (dev_clk_oe) quiet_cnt_r <= 11'h000;
    else if (quiet_cnt_r != 11'h7FF) quiet_cnt_r <= quiet_cnt_r + 11'h001;

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_drain;
    (dev_clk_oe -> !dev_clk_o) && (dev_data_oe -> !dev_data_o) &&
    (host_clk_oe -> !host_clk_o) && (host_data_oe -> !host_data_o);
  endproperty
  a_drain: assert property (p_drain)
    else $error("link line driven high");
  property p_low_half;
    $fell(dev_clk_oe) |-> lo_cnt_r == 11'h190;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("device clock low half not 400 cycles");
  property p_dev_data;
    $changed(dev_data_oe) |-> !dev_clk_oe;
  endproperty
  a_dev_data: assert property (p_dev_data)
    else $error("device data moved while clock held low");
  property p_start_clk;
    $rose(dev_data_oe) |-> ##[1:HALF_N] (dev_clk_oe || host_clk_oe);
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("no clock pulse after data pulled low");
  property p_gap;
    $rose(dev_data_oe) |-> quiet_cnt_r < 11'h008 || quiet_cnt_r >= 11'h3E8;
  endproperty
  a_gap: assert property (p_gap)
    else $error("frame started without the 100 us gap");
  property p_rts;
    clk_line && !data_line && host_data_oe && !host_clk_oe && !dev_clk_oe
      |-> ##[1:RTS_N] dev_clk_oe;
  endproperty
  a_rts: assert property (p_rts)
    else $error("request to send not clocked");
  property p_host_inh;
    $fell(host_clk_oe) |-> hlo_cnt_r >= 11'h3E8;
  endproperty
  a_host_inh: assert property (p_host_inh)
    else $error("host clock hold shorter than 100 us");
  property p_host_data;
    $changed(host_data_oe) |-> !clk_line;
  endproperty
  a_host_data: assert property (p_host_data)
    else $error("host data moved while clock high");

  c_tx: cover property ($rose(dev_data_oe) && quiet_cnt_r >= 11'h3E8);
  c_rts: cover property (host_data_oe && !host_clk_oe && clk_line);
  c_inh: cover property ($fell(host_clk_oe) && !host_data_oe);
endmodule : kmdl_checker

//--- kmdl_test.sv
// Self-checking bench: device and host ends joined over the link
`timescale 1ns/1ps
module kmdl_test;
  logic        clock;
  logic        rst_n;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        word_first;
  logic [3:0]  len_sel;
  logic        fifo_clr;
  logic        ovr;
  logic        f_clk;
  logic        f_dat;
  logic        ev_clr;
  logic        ev_flag;
  logic [7:0]  rx_data;
  logic        frame_error;
  logic [7:0]  send_data;
  logic        send_valid;
  logic        send_ready;
  logic        send_acked;
  logic        inhibit;
  logic [7:0]  recv_data;
  logic        recv_valid;
  logic        recv_error;
  logic [31:0] seed;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [10:0] frm;
  int          num_errors;
  int          n_checks;
  int          cyc;

  kmdl_link_if i_link ();
  kmdl_device i_kmdl_device (.clock(clock), .rst_n(rst_n), .link(i_link),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .transmit_word_first(word_first), .transmit_length_select(len_sel),
    .fifo_pointer_clear(fifo_clr), .soft_override(ovr),
    .force_clock_value(f_clk), .force_data_value(f_dat),
    .receive_event_clear(ev_clr), .receive_event_flag(ev_flag),
    .rx_data(rx_data), .frame_error(frame_error));
  kmdl_host i_kmdl_host (.clock(clock), .rst_n(rst_n), .link(i_link),
    .send_data(send_data), .send_valid(send_valid),
    .send_ready(send_ready), .send_acked(send_acked), .inhibit(inhibit),
    .recv_data(recv_data), .recv_valid(recv_valid),
    .recv_error(recv_error));
  kmdl_checker i_kmdl_checker (.clock(clock), .rst_n(rst_n),
    .dev_clk_o(i_link.dev_clk_o), .dev_clk_oe(i_link.dev_clk_oe),
    .dev_data_o(i_link.dev_data_o), .dev_data_oe(i_link.dev_data_oe),
    .host_clk_o(i_link.host_clk_o), .host_clk_oe(i_link.host_clk_oe),
    .host_data_o(i_link.host_data_o), .host_data_oe(i_link.host_data_oe),
    .clk_line(i_link.clk_line), .data_line(i_link.data_line));

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task tick;
    @(posedge clock);
    #10;
  endtask : tick

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  function automatic logic [10:0] exp_frame(input logic [7:0] d);
    return {1'b1, ~^d, d, 1'b0};
  endfunction : exp_frame

  task chk_val(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_val

  task chk_bit(input logic got, input logic exp);
    chk_val({10'h000, got}, {10'h000, exp});
  endtask : chk_bit

  function automatic logic sel(input int k);
    case (k)
      0: return recv_valid;
      1: return send_acked;
      2: return ev_flag;
      3: return i_link.dev_clk_oe;
      default: return send_ready;
    endcase
  endfunction : sel

  task wait_ev(input int k, input int lim);
    int n;
    n = 0;
    while (sel(k) !== 1'b1 && n < lim)
    begin
      tick;
      n++;
    end
    chk_bit(n < lim, 1'b1);
  endtask : wait_ev

  task quiet(input int cycles);
    int n;
    n = 0;
    repeat (cycles)
    begin
      tick;
      if (i_link.dev_data_oe !== 1'b0) n++;
    end
    chk_val(11'(n), 11'h000);
  endtask : quiet

  task push(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    tick;
    tx_valid = 1'b0;
    tick;
  endtask : push

  task start_burst(input logic [3:0] n);
    len_sel = n;
    word_first = 1'b1;
    tick;
    word_first = 1'b0;
  endtask : start_burst

  // Samples the wire itself at each clock fall, first bit lands lowest
  task grab_frame(output logic [10:0] f);
    repeat (11)
    begin
      @(negedge i_link.clk_line);
      f = {i_link.data_line, f[10:1]};
    end
  endtask : grab_frame

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Whole run needs about 49000 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, cyc, 0);
      complete_run;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    {tx_data, tx_valid, word_first, len_sel, fifo_clr, ovr} = '0;
    {ev_clr, send_data, send_valid, inhibit, rst_n} = '0;
    f_clk = 1'b1;
    f_dat = 1'b1;
    seed = 32'h000177AD;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge clock);
    #10;
    rst_n = 1'b1;
    tick;
    tick;
    b0 = 8'hFF;
    b1 = rnd();
    push(b0);
    push(b1);
    start_burst(4'h1);
    for (int i = 0; i < 2; i++)
    begin
      grab_frame(frm);
      chk_val(frm, exp_frame(i == 0 ? b0 : b1));
      wait_ev(0, 2000);
      chk_val({3'h0, recv_data}, {3'h0, i == 0 ? b0 : b1});
      chk_bit(recv_error, 1'b0);
    end
    $display("test burst finished");
    wait_ev(4, 100);
    b0 = rnd();
    send_data = b0;
    send_valid = 1'b1;
    tick;
    send_valid = 1'b0;
    wait_ev(1, 12000);
    wait_ev(2, 1000);
    chk_val({3'h0, rx_data}, {3'h0, b0});
    chk_bit(frame_error, 1'b0);
    $display("test host_send finished");
    // Flag still set from the byte above, so this one must wait
    push(8'h00);
    start_burst(4'h0);
    quiet(3000);
    ev_clr = 1'b1;
    tick;
    ev_clr = 1'b0;
    chk_bit(ev_flag, 1'b0);
    wait_ev(3, 2000);
    repeat (1200) tick;
    inhibit = 1'b1;
    repeat (1500) tick;
    inhibit = 1'b0;
    wait_ev(0, 14000);
    chk_val({3'h0, recv_data}, 11'h000);
    chk_bit(recv_error, 1'b0);
    $display("test stall_inhibit finished");
    tx_valid = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      tx_data = rnd();
      tick;
    end
    chk_bit(tx_ready, 1'b0);
    tx_valid = 1'b0;
    fifo_clr = 1'b1;
    tick;
    fifo_clr = 1'b0;
    tick;
    chk_bit(tx_ready, 1'b1);
    start_burst(4'hF);
    quiet(1500);
    $display("test fifo_clear finished");
    // Forced pulse keeps the link's own half-bit timing
    ovr = 1'b1;
    tick;
    f_dat = 1'b0;
    repeat (400) tick;
    chk_bit(i_link.data_line, 1'b0);
    f_clk = 1'b0;
    repeat (400) tick;
    chk_bit(i_link.clk_line, 1'b0);
    f_clk = 1'b1;
    tick;
    f_dat = 1'b1;
    tick;
    tick;
    chk_bit(i_link.data_line, 1'b1);
    $display("test override finished");
    complete_run;
  end
endmodule : kmdl_test
